// ==== hdl/dtl_core.sv ====
// Purpose: Dancer or tension PI loop for a feeding roll, with AXI4-Lite registers.
// Assumes: Feedback arrives as a signed sample in mV (voltage) or uA (current).
// Notes: Correction output is signed mV; one control update every 1 ms.
// Summary of operation
// - Signal type 1 reads feedback as +/-10 V, type 2 as +/-20 mA.
// - Proportional gain applies to error, settable 0 to 9999.
// - Integration time zero disables integral, proportional control only.
// - Integration time is seconds in ms steps, 0.001 fast to 1.000 slow.
// - No reaction while feedback stays inside programmable band, 0 to 100.0%.
// - Target is signed percent of full scale, zero means signal midpoint.
// - Alarm asserts when feedback passes plus or minus X percent.
// - Correction magnitude clamps to programmable ceiling 0 to 9999 mV.
// - Dancer settings act only in mode 1 or 2, ignored otherwise.
// - Access code definition zero leaves parameters freely readable and writable.
// - Nonzero code protects parameters until matching code input is written.
// - Mode 1 rising feedback speeds roll; mode 2 falling feedback speeds roll.
// - In mode 1 or 2 the position counter is off, dancer drives correction.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dtl_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] feedback,
	output logic signed [15:0] correction,
	output logic dancer_alarm,
	output logic position_counter_en,
	output logic irq
);
	localparam int CW = $clog2(dtl_pkg::CYCLE_CLKS);

	logic [1:0] mode, next_mode;
	logic [1:0] sig_type, next_sig_type;
	logic [13:0] pgain, next_pgain;
	logic [9:0] itime, next_itime;
	logic [9:0] window, next_window;
	logic signed [10:0] offset, next_offset;
	logic [9:0] alarm_pct, next_alarm_pct;
	logic [13:0] max_corr, next_max_corr;
	logic [26:0] code_def, next_code_def;
	logic [26:0] code_in, next_code_in;
	logic [2:0] irq_stat, next_irq_stat;
	logic [2:0] irq_mask, next_irq_mask;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [CW-1:0] tick_cnt, next_tick_cnt;
	logic signed [31:0] integ, next_integ;
	logic signed [15:0] next_corr;
	logic next_alarm, clamped;

	// Scale a tenths-of-percent value to converter units for the selected type.
	function automatic logic signed [31:0] dtl_pct_to_units(input logic signed [31:0] pct,
			input logic [1:0] st);
		logic signed [31:0] fs;
		fs = (st == dtl_pkg::SIG_CURR) ? 32'(dtl_pkg::FS_CURR) : 32'(dtl_pkg::FS_VOLT);
		return (pct * fs) / 32'sd1000;
	endfunction

	// Parameters are reachable only when unprotected or unlocked by the matching code.
	logic access_ok;
	assign access_ok = (code_def == 27'h0) || (code_in == code_def);

	// Reads of the protected range are refused while locked.
	logic rd_prot_c;
	assign rd_prot_c = !access_ok && s_axi_araddr[7:0] <= dtl_pkg::OFS_CODEDEF;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave. Address and data may arrive in either order.
	logic wr_go, rd_go;
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// Next state of the bus side and the parameter registers.
	always_comb begin
		logic [7:0] a;
		logic [31:0] d;
		logic wr_prot;
		a = 8'h0;
		wr_prot = 1'b0;
		d = 32'h0;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		wr_go = next_aw_held && next_w_held && !bvalid;
		next_mode = mode;
		next_sig_type = sig_type;
		next_pgain = pgain;
		next_itime = itime;
		next_window = window;
		next_offset = offset;
		next_alarm_pct = alarm_pct;
		next_max_corr = max_corr;
		next_code_def = code_def;
		next_code_in = code_in;
		next_irq_mask = irq_mask;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		// Partial strobes are refused for every field, even those that fit in one byte lane.
		wr_prot = !access_ok && next_aw_addr <= dtl_pkg::OFS_CODEDEF;
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = dtl_pkg::RESP_OKAY;
			d = next_w_data;
			if (wr_prot || next_w_strb != 4'hF) begin
				next_bresp = dtl_pkg::RESP_SLVERR;
			end else begin
				unique case (next_aw_addr)
					dtl_pkg::OFS_MODE: next_mode = d[1:0];
					dtl_pkg::OFS_SIGTYPE: next_sig_type = d[1:0];
					dtl_pkg::OFS_PGAIN: next_pgain = (d > 32'(dtl_pkg::PGAIN_MAX)) ?
							dtl_pkg::PGAIN_MAX : d[13:0];
					dtl_pkg::OFS_ITIME: next_itime = (d > 32'(dtl_pkg::ITIME_MAX)) ?
							dtl_pkg::ITIME_MAX : d[9:0];
					dtl_pkg::OFS_WINDOW: next_window = (d > 32'(dtl_pkg::PCT_MAX)) ?
							dtl_pkg::PCT_MAX : d[9:0];
					dtl_pkg::OFS_OFFSET: begin
						if ($signed(d) > 32'sd1000) next_offset = 11'sd1000;
						else if ($signed(d) < -32'sd1000) next_offset = -11'sd1000;
						else next_offset = d[10:0];
					end
					dtl_pkg::OFS_ALARM: next_alarm_pct = (d > 32'(dtl_pkg::PCT_MAX)) ?
							dtl_pkg::PCT_MAX : d[9:0];
					dtl_pkg::OFS_MAXCORR: next_max_corr = (d > 32'(dtl_pkg::CORR_MAX)) ?
							dtl_pkg::CORR_MAX : d[13:0];
					dtl_pkg::OFS_CODEDEF: next_code_def = (d > 32'(dtl_pkg::CODE_MAX)) ?
							dtl_pkg::CODE_MAX : d[26:0];
					dtl_pkg::OFS_CODEIN: next_code_in = d[26:0];
					dtl_pkg::OFS_IRQMASK: next_irq_mask = d[2:0];
					dtl_pkg::OFS_STATUS, dtl_pkg::OFS_IRQSTAT, dtl_pkg::OFS_CORR: ;
					default: next_bresp = dtl_pkg::RESP_SLVERR;
				endcase
			end
		end
		// Read side.
		next_rvalid = rvalid && !s_axi_rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rresp = rd_prot_c ? dtl_pkg::RESP_SLVERR : dtl_pkg::RESP_OKAY;
			a = s_axi_araddr[7:0];
			unique case (a)
				dtl_pkg::OFS_MODE: next_rdata = {30'h0, mode};
				dtl_pkg::OFS_SIGTYPE: next_rdata = {30'h0, sig_type};
				dtl_pkg::OFS_PGAIN: next_rdata = {18'h0, pgain};
				dtl_pkg::OFS_ITIME: next_rdata = {22'h0, itime};
				dtl_pkg::OFS_WINDOW: next_rdata = {22'h0, window};
				dtl_pkg::OFS_OFFSET: next_rdata = 32'(offset);
				dtl_pkg::OFS_ALARM: next_rdata = {22'h0, alarm_pct};
				dtl_pkg::OFS_MAXCORR: next_rdata = {18'h0, max_corr};
				dtl_pkg::OFS_CODEDEF: next_rdata = {5'h0, code_def};
				dtl_pkg::OFS_CODEIN: next_rdata = 32'h0;
				dtl_pkg::OFS_STATUS: next_rdata = {29'h0, access_ok, position_counter_en,
						dancer_alarm};
				dtl_pkg::OFS_IRQSTAT: next_rdata = {29'h0, irq_stat};
				dtl_pkg::OFS_IRQMASK: next_rdata = {29'h0, irq_mask};
				dtl_pkg::OFS_CORR: next_rdata = 32'(correction);
				default: begin
					next_rdata = 32'h0;
					next_rresp = dtl_pkg::RESP_SLVERR;
				end
			endcase
			if (rd_prot_c) next_rdata = 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control loop. The sample is taken once per cycle so gain and time scale stay fixed.
	logic tick;
	assign tick = (tick_cnt == CW'(dtl_pkg::CYCLE_CLKS - 1));
	logic dancer_on;
	assign dancer_on = (mode == dtl_pkg::MODE_RISE) || (mode == dtl_pkg::MODE_FALL);
	assign position_counter_en = !dancer_on;

	always_comb begin
		logic signed [31:0] target, err, band, lim, p, sum, thr, fb;
		fb = 32'(feedback);
		target = dtl_pct_to_units(32'(offset), sig_type);
		band = dtl_pct_to_units(32'(window), sig_type);
		thr = dtl_pct_to_units(32'(alarm_pct), sig_type);
		lim = 32'(max_corr);
		// Mode 2 inverts the sense so a falling signal raises roll speed.
		err = (mode == dtl_pkg::MODE_FALL) ? target - fb : fb - target;
		// The gain is cast signed, or a negative error would be multiplied as unsigned.
		p = (err * $signed(32'(pgain))) / dtl_pkg::GAIN_UNITY;
		sum = 32'sd0;
		next_tick_cnt = tick ? '0 : tick_cnt + CW'(1);
		next_integ = integ;
		next_corr = correction;
		next_alarm = dancer_alarm;
		clamped = 1'b0;
		if (!dancer_on) begin
			next_integ = 32'sd0;
			next_corr = 16'sd0;
			next_alarm = 1'b0;
		end else if (tick) begin
			next_alarm = (fb > thr) || (fb < -thr);
			if (err <= band && err >= -band) begin
				sum = 32'sd0;
			end else begin
				// Integral step per 1 ms cycle is p divided by Ti in ms.
				if (itime == 10'h0) next_integ = 32'sd0;
				else next_integ = integ + p / $signed(32'(itime));
				if (next_integ > lim) next_integ = lim;
				else if (next_integ < -lim) next_integ = -lim;
				sum = p + next_integ;
			end
			if (sum > lim) begin
				sum = lim;
				clamped = 1'b1;
			end else if (sum < -lim) begin
				sum = -lim;
				clamped = 1'b1;
			end
			next_corr = sum[15:0];
		end
		// Events are sticky; a set wins over the read-clear.
		next_irq_stat = (rd_go && s_axi_araddr[7:0] == dtl_pkg::OFS_IRQSTAT && !rd_prot_c) ?
				3'h0 : irq_stat;
		next_irq_stat[dtl_pkg::IRQ_ALARM_SET] |= next_alarm && !dancer_alarm;
		next_irq_stat[dtl_pkg::IRQ_ALARM_CLR] |= !next_alarm && dancer_alarm;
		next_irq_stat[dtl_pkg::IRQ_CLAMP] |= clamped;
	end
	assign irq = |(irq_stat & irq_mask);

	// Registers; every state clears on reset except sig_type (voltage) and alarm_pct (100.0%).
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= dtl_pkg::MODE_OFF;
			sig_type <= dtl_pkg::SIG_VOLT;
			pgain <= '0;
			itime <= '0;
			window <= '0;
			offset <= '0;
			alarm_pct <= dtl_pkg::PCT_MAX;
			max_corr <= '0;
			code_def <= '0;
			code_in <= '0;
			irq_stat <= '0;
			irq_mask <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= '0;
			rvalid <= 1'b0;
			rresp <= '0;
			rdata <= '0;
			tick_cnt <= '0;
			integ <= '0;
			correction <= '0;
			dancer_alarm <= 1'b0;
		end else begin
			mode <= next_mode;
			sig_type <= next_sig_type;
			pgain <= next_pgain;
			itime <= next_itime;
			window <= next_window;
			offset <= next_offset;
			alarm_pct <= next_alarm_pct;
			max_corr <= next_max_corr;
			code_def <= next_code_def;
			code_in <= next_code_in;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			tick_cnt <= next_tick_cnt;
			integ <= next_integ;
			correction <= next_corr;
			dancer_alarm <= next_alarm;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	// The ceiling is checked against the value in force at the update edge.
	a_corr_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> correction <= $signed({18'h0, $past(max_corr)}) &&
		correction >= -$signed({18'h0, $past(max_corr)}))
		else $error("Correction beyond ceiling.");
	a_off_mode_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!dancer_on |=> correction == 16'sd0 && !dancer_alarm)
		else $error("Output active outside dancer mode.");
	a_counter_off: assert property (@(posedge aclk) disable iff (!aresetn)
		position_counter_en == (mode == dtl_pkg::MODE_OFF || mode == 2'h3))
		else $error("Position counter enable wrong.");
	a_hold_between: assert property (@(posedge aclk) disable iff (!aresetn)
		dancer_on && !tick && $stable(mode) |=> $stable(correction))
		else $error("Correction moved between cycles.");
	a_locked_write: assert property (@(posedge aclk) disable iff (!aresetn)
		!access_ok && wr_go && next_aw_addr == dtl_pkg::OFS_PGAIN |=> $stable(pgain))
		else $error("Protected write landed.");
	a_free_write: assert property (@(posedge aclk) disable iff (!aresetn)
		code_def == 27'h0 && wr_go && next_aw_addr == dtl_pkg::OFS_PGAIN && next_w_strb == 4'hF
		|=> bresp == dtl_pkg::RESP_OKAY)
		else $error("Unprotected write refused.");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == |(irq_stat & irq_mask))
		else $error("Interrupt level wrong.");
	// While the dancer runs, no event can arrive between updates, so a status read must leave it empty.
	a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go && s_axi_araddr[7:0] == dtl_pkg::OFS_IRQSTAT && dancer_on && !tick
		|=> irq_stat == 3'h0)
		else $error("Status read did not clear events.");
	a_alarm_event: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(dancer_alarm) |-> irq_stat[dtl_pkg::IRQ_ALARM_SET])
		else $error("Alarm rise not recorded.");
	a_p_only: assert property (@(posedge aclk) disable iff (!aresetn)
		dancer_on && itime == 10'h0 && tick |=> integ == 32'sd0)
		else $error("Integral active with zero time.");
endmodule

// ==== pkg/dtl_pkg.sv ====
// Purpose: Shared constants for the dancer tension loop block.
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz clock.
// Notes: Percentages are held in tenths of a percent (1000 = 100.0%).
package dtl_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_SIGTYPE = 8'h04;
	localparam logic [7:0] OFS_PGAIN = 8'h08;
	localparam logic [7:0] OFS_ITIME = 8'h0C;
	localparam logic [7:0] OFS_WINDOW = 8'h10;
	localparam logic [7:0] OFS_OFFSET = 8'h14;
	localparam logic [7:0] OFS_ALARM = 8'h18;
	localparam logic [7:0] OFS_MAXCORR = 8'h1C;
	localparam logic [7:0] OFS_CODEDEF = 8'h20;
	localparam logic [7:0] OFS_CODEIN = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_IRQSTAT = 8'h2C;
	localparam logic [7:0] OFS_IRQMASK = 8'h30;
	localparam logic [7:0] OFS_CORR = 8'h34;
	// Setting limits.
	localparam logic [13:0] PGAIN_MAX = 14'h270F;
	localparam logic [9:0] ITIME_MAX = 10'h3E8;
	localparam logic [9:0] PCT_MAX = 10'h3E8;
	localparam logic [13:0] CORR_MAX = 14'h270F;
	localparam logic [26:0] CODE_MAX = 27'h5F5E0FF;
	// Signal type and mode codes.
	localparam logic [1:0] SIG_VOLT = 2'h1;
	localparam logic [1:0] SIG_CURR = 2'h2;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	// Full scale of the converter: 10 V as 10000 mV, 20 mA as 20000 uA.
	localparam logic [15:0] FS_VOLT = 16'h2710;
	localparam logic [15:0] FS_CURR = 16'h4E20;
	// Control cycle of 1 ms at 100 MHz.
	localparam int CLK_MHZ = 100;
	localparam int CYCLE_US = 1000;
	localparam int CYCLE_CLKS = CLK_MHZ * CYCLE_US;
	// Interrupt bits.
	localparam int IRQ_ALARM_SET = 0;
	localparam int IRQ_ALARM_CLR = 1;
	localparam int IRQ_CLAMP = 2;
	localparam int IRQ_BITS = 3;
	// Proportional scaling: gain 1000 gives unity.
	localparam int GAIN_UNITY = 1000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verification/dtl_far_model.sv ====
// Purpose: Behavioural dancer sensor and feeding roll drive at the block's far side.
// Assumes: Voltage feedback, so one feedback unit is one millivolt.
// Notes: The sensor level moves only when the bench asks, just after a clock edge.
`timescale 1ns/1ps
module dtl_far_model (
	input wire logic aclk,
	input wire logic signed [15:0] correction,
	output logic signed [15:0] feedback
);
	logic signed [15:0] drive_cmd;

	////////////////////////////////////////////////////////////////////////////////
	// The sensor starts at the midpoint of a bipolar signal.
	initial begin
		feedback = 16'sh0000;
	end

	// Set the dancer level in mV; the value stays within +/-10000 for voltage type.
	task automatic set_mv(input logic signed [15:0] mv);
		@(posedge aclk);
		feedback <= mv;
	endtask

	// The drive follows the correction command at every edge.
	always @(posedge aclk) begin
		drive_cmd <= correction;
	end
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the dancer tension loop over AXI4-Lite.
// Assumes: One control tick near 100000 clocks after reset release.
// Notes: Register and protection checks finish before the first tick; interrupt checks follow it.
`timescale 1ns/1ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, alarm, pos_en, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, data;
	logic signed [15:0] feedback, correction;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 10 ns period.
	always #5 aclk = ~aclk;

	dtl_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .feedback(feedback), .correction(correction),
		.dancer_alarm(alarm), .position_counter_en(pos_en), .irq(irq));

	dtl_far_model u_far (.aclk(aclk), .correction(correction), .feedback(feedback));

	////////////////////////////////////////////////////////////////////////////////
	// Report the counts and the verdict, then stop.
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compare one value against its expectation.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A hang is cut short well after the single control tick.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 130000) begin
			mismatches++;
			test_done();
		end
	end

	// One write; address and data are offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		awaddr <= {24'h0, a};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		// One edge passes so a following call never raises bready in the same step.
		@(posedge aclk);
	endtask

	// One read; rready is held until the data are sampled.
	task automatic rd(input logic [7:0] a);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (rvalid) begin
				resp = rresp;
				data = rdata;
				rready <= 1'b0;
				break;
			end
			if (arvalid && arready) arvalid <= 1'b0;
		end
		// One edge passes so a following call never raises rready in the same step.
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: registers and protection first, then one loop update.
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(pos_en, 1'b1);
		rd(dtl_pkg::OFS_STATUS); chk(data, 32'h6);
		rd(dtl_pkg::OFS_ALARM); chk(data, 32'h3E8);
		rd(dtl_pkg::OFS_SIGTYPE); chk(data, 32'h1);
		wr(dtl_pkg::OFS_PGAIN, 32'hFFFF, 4'hF); chk(resp, dtl_pkg::RESP_OKAY);
		rd(dtl_pkg::OFS_PGAIN); chk(data, 32'h270F);
		wr(8'h40, 32'h1, 4'hF); chk(resp, dtl_pkg::RESP_SLVERR);
		rd(8'h40); chk(resp, dtl_pkg::RESP_SLVERR);
		chk(data, 32'h0);
		wr(dtl_pkg::OFS_PGAIN, 32'h1, 4'h3); chk(resp, dtl_pkg::RESP_SLVERR);
		// Lock, try a setting, then unlock with the matching code.
		wr(dtl_pkg::OFS_CODEDEF, 32'h5, 4'hF); chk(resp, dtl_pkg::RESP_OKAY);
		wr(dtl_pkg::OFS_PGAIN, 32'h7D0, 4'hF); chk(resp, dtl_pkg::RESP_SLVERR);
		rd(dtl_pkg::OFS_PGAIN); chk(resp, dtl_pkg::RESP_SLVERR);
		chk(data, 32'h0);
		wr(dtl_pkg::OFS_CODEIN, 32'h4, 4'hF);
		wr(dtl_pkg::OFS_PGAIN, 32'h7D0, 4'hF); chk(resp, dtl_pkg::RESP_SLVERR);
		wr(dtl_pkg::OFS_CODEIN, 32'h5, 4'hF);
		wr(dtl_pkg::OFS_PGAIN, 32'h7D0, 4'hF); chk(resp, dtl_pkg::RESP_OKAY);
		rd(dtl_pkg::OFS_PGAIN); chk(data, 32'h7D0);
		// Gain 2.0, no integral, 10% band, 40% alarm, 3000 mV ceiling.
		wr(dtl_pkg::OFS_ITIME, 32'h0, 4'hF);
		wr(dtl_pkg::OFS_WINDOW, 32'h64, 4'hF);
		wr(dtl_pkg::OFS_OFFSET, 32'h0, 4'hF);
		wr(dtl_pkg::OFS_ALARM, 32'h190, 4'hF);
		wr(dtl_pkg::OFS_MAXCORR, 32'hBB8, 4'hF);
		wr(dtl_pkg::OFS_IRQMASK, 32'h7, 4'hF);
		chk(correction, 16'h0000);
		wr(dtl_pkg::OFS_MODE, 32'h1, 4'hF);
		@(posedge aclk);
		chk(pos_en, 1'b0);
		u_far.set_mv(16'sd5000);
		// Wait for the first tick; the timeout bounds this wait.
		while (alarm !== 1'b1) @(posedge aclk);
		// The update lands one full cycle after the six reset edges and is seen one edge later.
		chk(cyc, 32'(dtl_pkg::CYCLE_CLKS + 6));
		@(posedge aclk);
		chk(correction, 16'h0BB8);
		chk(u_far.drive_cmd, 16'h0BB8);
		chk(alarm, 1'b1);
		chk(irq, 1'b1);
		rd(dtl_pkg::OFS_STATUS); chk(data, 32'h5);
		rd(dtl_pkg::OFS_IRQSTAT); chk(data, 32'h5);
		@(posedge aclk);
		chk(irq, 1'b0);
		rd(dtl_pkg::OFS_IRQSTAT); chk(data, 32'h0);
		test_done();
	end
endmodule
